// ### design/smf_mode_ctrl.sv
/*
 * Operating-mode sequencer of a networked safety controller with
 * password-gated tool commands, AXI4-Lite registers, function enables,
 * status indicator drive and an interrupt.
 * Assumes all inputs synchronous to aclk; nonvolatile contents are
 * presented on nv_* inputs; only the password is updated through nv_pwd_wr.
 */
// Overview of operation
// - download, lock, reset, mode and password commands need matching password
// - registered password is kept in nonvolatile storage
// - no password by default; checking starts once one is registered
// - self-diagnosis runs before any other operating state
// - missing or bad configuration leads to configuring until download
// - idle supports only standard I/O exchange and messages
// - run supports user program, safety I/O, standard I/O, messages
// - switch setting change after configuration forces abort
// - abort halts all but messages and holds them safe
// - critical error halts everything including messages, held safe
// - indicator alternates green/red in diagnosis and configuring waits
// - run flag at status bit 6 set only in run
// - local I/O refreshed only in run, otherwise held safe
// - run to idle input data follows the standard area hold setting
// - download in run or idle only while unlocked
// - reset in configuring, run, idle, abort only if type allowed by lock
`timescale 1ns/1ns
`default_nettype none
module smf_mode_ctrl #(
  parameter int BLINK_CYC_P = smf_pkg::BLINK_CYC
) (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [smf_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [smf_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [smf_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [smf_pkg::DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic                         diag_done,
  input  wire logic                         diag_fail,
  input  wire logic                         network_unique_identifier_set,
  input  wire logic                         crit_err,
  input  wire logic [smf_pkg::SW_W-1:0]     sw_setting,
  input  wire logic                         nv_cfg_valid,
  input  wire logic                         nv_pwd_valid,
  input  wire logic [smf_pkg::PW_W-1:0]     nv_pwd,
  output logic                              nv_pwd_wr,
  output logic                              nv_pwd_set_out,
  output logic [smf_pkg::PW_W-1:0]          nv_pwd_out,
  output logic                              module_status_indicator_green,
  output logic                              module_status_indicator_red,
  output logic                              run_mode,
  output logic                              user_prog_en,
  output logic                              safety_io_en,
  output logic                              local_io_refresh,
  output logic                              local_io_safe,
  output logic                              std_io_en,
  output logic                              msg_en,
  output logic                              std_in_hold,
  output logic                              irq
);
  import smf_pkg::*;

  smf_state_t           state_r;
  smf_state_t           prev_r;
  smf_cmd_t             cmd_r;
  smf_rst_t             rtype_r;
  logic                 cmd_go_r;
  logic                 accept;
  logic                 locked_r;
  logic                 pw_set_r;
  logic [PW_W-1:0]      pw_r;
  logic [PW_W-1:0]      pw_given_r;
  logic [PW_W-1:0]      pw_new_r;
  logic                 cfg_ok_r;
  logic [SW_W-1:0]      sw_ref_r;
  logic                 loaded_r;
  logic                 hold_set_r;
  logic                 from_run_r;
  logic                 acc_r;
  logic                 ref_r;
  logic [ADDR_W-1:0]    awaddr_r;
  logic [DATA_W-1:0]    wdata_r;
  logic [3:0]           wstrb_r;
  logic                 wr_do;
  logic [DATA_W-1:0]    rd_data;
  logic                 rd_err;
  logic [DATA_W-1:0]    status_w;
  logic [IRQ_W-1:0]     irq_sts_r;
  logic [IRQ_W-1:0]     irq_sts_nxt;
  logic [IRQ_W-1:0]     irq_mask_r;
  logic [IRQ_W-1:0]     irq_ev;
  logic [IRQ_W-1:0]     irq_clr;
  logic [31:0]          blink_cnt_r;
  logic                 blink_tick;
  logic                 phase_r;

  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old_v,
    input logic [DATA_W-1:0] new_v,
    input logic [3:0]        strb
  );
    logic [DATA_W-1:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction : merge

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a == A_CTRL) || (a == A_PWD) || (a == A_NEWPWD) ||
           (a == A_CMD) || (a == A_STATUS) || (a == A_IRQ_STS) ||
           (a == A_IRQ_MASK) || (a == A_FUNC);
  endfunction : mapped

  smf_auth u_auth (
    .state     (state_r),
    .cmd       (cmd_r),
    .rtype     (rtype_r),
    .locked    (locked_r),
    .pw_set    (pw_set_r),
    .pw_given  (pw_given_r),
    .pw_stored (pw_r),
    .accept    (accept)
  );

  // both address and data held, no response pending
  assign wr_do = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  // write channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb_r       <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  always_comb begin
    status_w = '0;
    status_w[STS_MODE_LSB +: STS_MODE_W] = state_r;
    status_w[RUN_FLAG_BIT]  = run_mode;
    status_w[STS_LOCK_BIT]  = locked_r;
    status_w[STS_PWSET_BIT] = pw_set_r;
    status_w[STS_CFGOK_BIT] = cfg_ok_r;
    status_w[STS_ACC_BIT]   = acc_r;
    status_w[STS_REF_BIT]   = ref_r;
  end

  // passwords are write-only and read back as zero
  always_comb begin
    rd_data = '0;
    rd_err  = 1'b0;
    case (s_axi_araddr)
      A_CTRL:     rd_data[CTRL_HOLD_BIT] = hold_set_r;
      A_PWD:      rd_data = '0;
      A_NEWPWD:   rd_data = '0;
      A_CMD:      rd_data[CMD_LSB +: CMD_W] = cmd_r;
      A_STATUS:   rd_data = status_w;
      A_IRQ_STS:  rd_data[IRQ_W-1:0] = irq_sts_r;
      A_IRQ_MASK: rd_data[IRQ_W-1:0] = irq_mask_r;
      A_FUNC:     rd_data = {26'h0, msg_en, std_io_en, local_io_safe,
                             local_io_refresh, safety_io_en, user_prog_en};
      default:    rd_err = 1'b1;
    endcase
  end

  // software-written registers and command issue
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_set_r <= 1'b0;
      pw_given_r <= '0;
      pw_new_r   <= '0;
      cmd_r      <= CMD_NONE;
      rtype_r    <= RST_POWER;
      cmd_go_r   <= 1'b0;
      irq_mask_r <= '0;
    end else begin
      cmd_go_r <= 1'b0;
      if (wr_do) begin
        case (awaddr_r)
          A_CTRL: begin
            if (wstrb_r[0]) begin
              hold_set_r <= wdata_r[CTRL_HOLD_BIT];
            end
          end
          A_PWD:    pw_given_r <= merge(pw_given_r, wdata_r, wstrb_r);
          A_NEWPWD: pw_new_r   <= merge(pw_new_r, wdata_r, wstrb_r);
          A_CMD: begin
            if (wstrb_r[0]) begin
              cmd_r    <= smf_cmd_t'(wdata_r[CMD_LSB +: CMD_W]);
              rtype_r  <= smf_rst_t'(wdata_r[RTYPE_LSB +: RTYPE_W]);
              cmd_go_r <= 1'b1;
            end
          end
          A_IRQ_MASK: begin
            if (wstrb_r[0]) begin
              irq_mask_r <= wdata_r[IRQ_W-1:0];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // mode sequencing, configuration and password store
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r        <= ST_DIAG;
      locked_r       <= 1'b0;
      pw_set_r       <= 1'b0;
      pw_r           <= '0;
      cfg_ok_r       <= 1'b0;
      sw_ref_r       <= '0;
      loaded_r       <= 1'b0;
      acc_r          <= 1'b0;
      ref_r          <= 1'b0;
      nv_pwd_wr      <= 1'b0;
      nv_pwd_set_out <= 1'b0;
      nv_pwd_out     <= '0;
    end else begin
      nv_pwd_wr <= 1'b0;
      // stored contents are taken once, after reset release
      if (!loaded_r) begin
        pw_r     <= nv_pwd;
        pw_set_r <= nv_pwd_valid;
        cfg_ok_r <= nv_cfg_valid;
        sw_ref_r <= sw_setting;
        loaded_r <= 1'b1;
      end
      case (state_r)
        ST_DIAG: begin
          if (diag_fail) begin
            state_r <= ST_CRIT;
          end else if (loaded_r && diag_done &&
                       network_unique_identifier_set) begin
            state_r <= cfg_ok_r ? ST_IDLE : ST_CONFIG;
          end
        end
        ST_IDLE, ST_RUN: begin
          if (sw_setting != sw_ref_r) begin
            state_r <= ST_ABORT;
          end
        end
        ST_CONFIG, ST_ABORT, ST_CRIT: ;
        default: state_r <= ST_CRIT;
      endcase
      if (cmd_go_r) begin
        acc_r <= accept;
        ref_r <= !accept;
      end
      if (cmd_go_r && accept) begin
        case (cmd_r)
          CMD_DOWNLOAD: begin
            cfg_ok_r <= 1'b1;
            sw_ref_r <= sw_setting;
            if (state_r == ST_CONFIG) begin
              state_r <= ST_IDLE;
            end
          end
          CMD_LOCK:    locked_r <= 1'b1;
          CMD_UNLOCK:  locked_r <= 1'b0;
          CMD_TO_RUN:  state_r  <= ST_RUN;
          CMD_TO_IDLE: state_r  <= ST_IDLE;
          CMD_RESET: begin
            state_r <= ST_DIAG;
            if (rtype_r != RST_POWER) begin
              cfg_ok_r <= 1'b0;
              locked_r <= 1'b0;
            end
            if (rtype_r == RST_DEFAULT) begin
              pw_r           <= '0;
              pw_set_r       <= 1'b0;
              nv_pwd_out     <= '0;
              nv_pwd_set_out <= 1'b0;
              nv_pwd_wr      <= 1'b1;
            end
          end
          CMD_SET_PW: begin
            pw_r           <= pw_new_r;
            pw_set_r       <= 1'b1;
            nv_pwd_out     <= pw_new_r;
            nv_pwd_set_out <= 1'b1;
            nv_pwd_wr      <= 1'b1;
          end
          default: ;
        endcase
      end
      if (crit_err) begin
        state_r <= ST_CRIT;
      end
    end
  end

  // function enables follow the mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r           <= ST_DIAG;
      from_run_r       <= 1'b0;
      run_mode         <= 1'b0;
      user_prog_en     <= 1'b0;
      safety_io_en     <= 1'b0;
      local_io_refresh <= 1'b0;
      local_io_safe    <= 1'b1;
      std_io_en        <= 1'b0;
      msg_en           <= 1'b0;
      std_in_hold      <= 1'b0;
    end else begin
      prev_r           <= state_r;
      run_mode         <= (state_r == ST_RUN);
      user_prog_en     <= (state_r == ST_RUN);
      safety_io_en     <= (state_r == ST_RUN);
      local_io_refresh <= (state_r == ST_RUN);
      local_io_safe    <= (state_r != ST_RUN);
      std_io_en        <= (state_r == ST_RUN) ||
                          (state_r == ST_IDLE);
      msg_en           <= (state_r != ST_DIAG) &&
                          (state_r != ST_CRIT);
      if (state_r != ST_IDLE) begin
        from_run_r <= 1'b0;
      end else if (prev_r == ST_RUN) begin
        from_run_r <= 1'b1;
      end
      std_in_hold <= (state_r == ST_IDLE) && hold_set_r &&
                     (from_run_r || (prev_r == ST_RUN));
    end
  end

  // indicator blink divider
  assign blink_tick = (blink_cnt_r == 32'(BLINK_CYC_P - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blink_cnt_r <= '0;
      phase_r     <= 1'b0;
    end else if (blink_tick) begin
      blink_cnt_r <= '0;
      phase_r     <= !phase_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      module_status_indicator_green <= 1'b0;
      module_status_indicator_red   <= 1'b0;
    end else begin
      case (state_r)
        ST_DIAG, ST_CONFIG: begin
          module_status_indicator_green <= phase_r;
          module_status_indicator_red   <= !phase_r;
        end
        ST_RUN: begin
          module_status_indicator_green <= 1'b1;
          module_status_indicator_red   <= 1'b0;
        end
        ST_IDLE: begin
          module_status_indicator_green <= phase_r;
          module_status_indicator_red   <= 1'b0;
        end
        ST_ABORT: begin
          module_status_indicator_green <= 1'b0;
          module_status_indicator_red   <= phase_r;
        end
        default: begin
          module_status_indicator_green <= 1'b0;
          module_status_indicator_red   <= 1'b1;
        end
      endcase
    end
  end

  // sticky events; a new event beats a same-cycle clear
  always_comb begin
    irq_ev            = '0;
    irq_ev[IRQ_ACC]   = cmd_go_r && accept;
    irq_ev[IRQ_REF]   = cmd_go_r && !accept;
    irq_ev[IRQ_MODE]  = (state_r != prev_r);
    irq_ev[IRQ_ABORT] = (state_r == ST_ABORT) && (prev_r != ST_ABORT);
    irq_ev[IRQ_CRIT]  = (state_r == ST_CRIT) && (prev_r != ST_CRIT);
    irq_clr = '0;
    if (wr_do && (awaddr_r == A_IRQ_STS) && wstrb_r[0]) begin
      irq_clr = wdata_r[IRQ_W-1:0];
    end
    irq_sts_nxt = (irq_sts_r & ~irq_clr) | irq_ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_sts_r <= '0;
      irq       <= 1'b0;
    end else begin
      irq_sts_r <= irq_sts_nxt;
      irq       <= |(irq_sts_nxt & irq_mask_r);
    end
  end
endmodule : smf_mode_ctrl
`default_nettype wire

// ### common/smf_pkg.sv
/*
 * Shared constants and types of the safety controller mode sequencer:
 * register offsets, field positions, timing, states and commands.
 * Assumes a 100 MHz clock and a 32-bit AXI4-Lite register port.
 */
`default_nettype none
package smf_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int BLINK_HALF_NS = 500000000;
  localparam int BLINK_CYC     = BLINK_HALF_NS / CLK_PERIOD_NS;

  // widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PW_W   = 32;
  localparam int SW_W   = 8;
  localparam int IRQ_W  = 5;

  // register byte offsets
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_PWD      = 8'h04;
  localparam logic [7:0] A_NEWPWD   = 8'h08;
  localparam logic [7:0] A_CMD      = 8'h0c;
  localparam logic [7:0] A_STATUS   = 8'h10;
  localparam logic [7:0] A_IRQ_STS  = 8'h14;
  localparam logic [7:0] A_IRQ_MASK = 8'h18;
  localparam logic [7:0] A_FUNC     = 8'h1c;

  // field positions
  localparam int CTRL_HOLD_BIT = 0;
  localparam int CMD_LSB       = 0;
  localparam int CMD_W         = 4;
  localparam int RTYPE_LSB     = 4;
  localparam int RTYPE_W       = 2;
  localparam int STS_MODE_LSB  = 0;
  localparam int STS_MODE_W    = 3;
  localparam int RUN_FLAG_BIT  = 6;
  localparam int STS_LOCK_BIT  = 7;
  localparam int STS_PWSET_BIT = 8;
  localparam int STS_CFGOK_BIT = 9;
  localparam int STS_ACC_BIT   = 10;
  localparam int STS_REF_BIT   = 11;
  localparam int IRQ_ACC       = 0;
  localparam int IRQ_REF       = 1;
  localparam int IRQ_MODE      = 2;
  localparam int IRQ_ABORT     = 3;
  localparam int IRQ_CRIT      = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_DIAG, ST_CONFIG, ST_IDLE, ST_RUN, ST_ABORT, ST_CRIT
  } smf_state_t;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_DOWNLOAD, CMD_LOCK, CMD_UNLOCK, CMD_RESET,
    CMD_TO_RUN, CMD_TO_IDLE, CMD_SET_PW, CMD_MONITOR
  } smf_cmd_t;

  typedef enum logic [1:0] {
    RST_POWER, RST_DEFAULT, RST_RETAIN, RST_BAD
  } smf_rst_t;
endpackage : smf_pkg
`default_nettype wire

// ### design/smf_auth.sv
/*
 * Command admission: decides whether a tool command is allowed in the
 * present mode and lock state and whether its password matches.
 * Purely combinational; the caller registers the decision.
 */
`timescale 1ns/1ns
`default_nettype none
module smf_auth (
  input  wire smf_pkg::smf_state_t        state,
  input  wire smf_pkg::smf_cmd_t          cmd,
  input  wire smf_pkg::smf_rst_t          rtype,
  input  wire logic                       locked,
  input  wire logic                       pw_set,
  input  wire logic [smf_pkg::PW_W-1:0]   pw_given,
  input  wire logic [smf_pkg::PW_W-1:0]   pw_stored,
  output logic                            accept
);
  import smf_pkg::*;

  logic pw_ok;
  logic allowed;
  logic live;
  logic run_idle;

  // no password registered means no check
  assign pw_ok    = !pw_set || (pw_given == pw_stored);
  assign live     = (state != ST_DIAG) && (state != ST_CRIT);
  assign run_idle = (state == ST_RUN) || (state == ST_IDLE);

  always_comb begin
    allowed = 1'b0;
    case (cmd)
      CMD_DOWNLOAD:
        allowed = (state == ST_CONFIG) || (run_idle && !locked);
      CMD_LOCK, CMD_UNLOCK:
        allowed = run_idle;
      CMD_RESET:
        allowed = live && ((rtype == RST_POWER) ||
                  ((rtype != RST_BAD) && !locked));
      CMD_TO_RUN:  allowed = (state == ST_IDLE);
      CMD_TO_IDLE: allowed = (state == ST_RUN);
      CMD_SET_PW:  allowed = live;
      CMD_MONITOR: allowed = live;
      default:     allowed = 1'b0;
    endcase
  end

  // every command except monitoring needs the password
  assign accept = allowed && ((cmd == CMD_MONITOR) || pw_ok);
endmodule : smf_auth
`default_nettype wire

// ### dv/smf_nv_model.sv
/* Nonvolatile password store facing the mode sequencer.
   Assumes nv_pwd_wr is a one-cycle pulse in the aclk domain. */
`timescale 1ns/1ns
`default_nettype none
module smf_nv_model (
  input  wire logic                      aclk,
  input  wire logic                      nv_pwd_wr,
  input  wire logic                      nv_pwd_set_out,
  input  wire logic [smf_pkg::PW_W-1:0]  nv_pwd_out,
  output logic                           nv_pwd_valid,
  output logic [smf_pkg::PW_W-1:0]       nv_pwd
);
  import smf_pkg::*;
  initial begin
    nv_pwd_valid = 1'b0;
    nv_pwd = 32'h0;
  end
  // contents survive aresetn of the sequencer; a default reset command rewrites them cleared
  always @(posedge aclk) begin
    if (nv_pwd_wr) begin
      nv_pwd_valid <= nv_pwd_set_out;
      nv_pwd <= nv_pwd_out;
    end
  end
endmodule : smf_nv_model
`default_nettype wire

// ### dv/smf_mode_ctrl_properties.sv
/* Checker of the mode sequencer's function enables and indicator.
   Assumes it is bound to smf_mode_ctrl and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module smf_mode_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic crit_err,
  input wire logic nv_pwd_wr,
  input wire logic module_status_indicator_green,
  input wire logic module_status_indicator_red,
  input wire logic run_mode,
  input wire logic user_prog_en,
  input wire logic safety_io_en,
  input wire logic local_io_refresh,
  input wire logic local_io_safe,
  input wire logic std_io_en,
  input wire logic msg_en
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_flag; run_mode |-> local_io_refresh && !local_io_safe; endproperty
  a_flag: assert property (p_flag) else $error("run flag bad");
  property p_safe; local_io_safe != local_io_refresh; endproperty
  a_safe: assert property (p_safe) else $error("local io bad");
  property p_run; run_mode |-> user_prog_en && safety_io_en && std_io_en
    && msg_en; endproperty
  a_run: assert property (p_run) else $error("run enables bad");
  property p_idle; std_io_en && !run_mode |-> !user_prog_en && !safety_io_en
    && msg_en; endproperty
  a_idle: assert property (p_idle) else $error("idle enables bad");
  property p_abort; msg_en && !std_io_en |-> !user_prog_en && !safety_io_en
    && local_io_safe; endproperty
  a_abort: assert property (p_abort) else $error("abort bad");
  property p_crit; $rose(crit_err) |-> ##[1:3] (!msg_en && !std_io_en
    && local_io_safe); endproperty
  a_crit: assert property (p_crit) else $error("crit halt bad");
  property p_red; $rose(crit_err) |-> ##[2:4] (module_status_indicator_red
    && !module_status_indicator_green); endproperty
  a_red: assert property (p_red) else $error("crit red bad");
  property p_nvwr; nv_pwd_wr |=> !nv_pwd_wr; endproperty
  a_nvwr: assert property (p_nvwr) else $error("nv write long");
endmodule : smf_mode_props
bind smf_mode_ctrl smf_mode_props smf_mode_props_i (.aclk, .aresetn,
  .crit_err, .nv_pwd_wr, .module_status_indicator_green,
  .module_status_indicator_red, .run_mode, .user_prog_en, .safety_io_en,
  .local_io_refresh, .local_io_safe, .std_io_en, .msg_en);
`default_nettype wire

// ### dv/tb_safety_controller_mode_fsm.sv
/* Self-checking bench of the mode sequencer over AXI4-Lite.
   Assumes the nonvolatile store model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module tb_safety_controller_mode_fsm;
  import smf_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, irq;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, diag_done, diag_fail;
  logic network_unique_identifier_set, crit_err, nv_cfg_valid, nv_pwd_valid;
  logic nv_pwd_wr, nv_pwd_set_out, module_status_indicator_green, run_mode;
  logic module_status_indicator_red, user_prog_en, safety_io_en, msg_en;
  logic local_io_refresh, local_io_safe, std_io_en, std_in_hold;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, sw_setting;
  logic [31:0] s_axi_wdata, s_axi_rdata, nv_pwd, nv_pwd_out, pw, d;
  int          failures, cmp_count, cyc;
  smf_mode_ctrl #(.BLINK_CYC_P(4)) smf_mode_ctrl_i (.*);
  smf_nv_model smf_nv_model_i (.*);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
  // FUNC: msg, std io, local safe, local refresh, safety io, user program
  function automatic logic [31:0] fx(input logic [2:0] m);
    return {26'h0, m inside {3'd1, 3'd2, 3'd3, 3'd4}, m inside {3'd2, 3'd3},
      m != 3'd3, m == 3'd3, m == 3'd3, m == 3'd3};
  endfunction : fx
  task automatic st(input logic [2:0] m);
    repeat (3) @(posedge aclk);
    chk(run_mode, m == 3'd3);
    if (m == 3'd3) chk(module_status_indicator_green, 1'b1);
    if (m == 3'd5) chk(module_status_indicator_red, 1'b1);
    // status read last so that cmd sees the accepted and refused bits
    rd(A_FUNC);
    chk(d, fx(m));
    rd(A_STATUS);
    chk({d[6], d[2:0]}, {m == 3'd3, m});
  endtask : st
  task automatic cmd(input smf_cmd_t c, input logic [1:0] t,
    input logic [31:0] p, input logic [2:0] m, input logic ok);
    wr(A_PWD, p);
    wr(A_CMD, {26'h0, t, c});
    st(m);
    chk(d[11:10], {!ok, ok});
  endtask : cmd
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, diag_done} = '0;
    {diag_fail, network_unique_identifier_set, crit_err, nv_cfg_valid} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
    void'($urandom(92420));
    pw = $urandom;
    sw_setting = 8'($urandom);
    d = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (16) begin
      @(posedge aclk);
      d[1:0] = d[1:0] | {module_status_indicator_green,
        module_status_indicator_red};
    end
    chk(d[1:0], 2'b11);
    diag_done <= 1'b1;
    st(3'd0);
    network_unique_identifier_set <= 1'b1;
    st(3'd1);
    cmd(CMD_LOCK, 2'd0, 32'h0, 3'd1, 1'b0);
    cmd(CMD_DOWNLOAD, 2'd0, 32'h0, 3'd2, 1'b1);
    wr(A_NEWPWD, pw);
    cmd(CMD_SET_PW, 2'd0, 32'h0, 3'd2, 1'b1);
    chk(nv_pwd, pw);
    repeat (3) cmd(CMD_TO_RUN, 2'd0, pw ^ ($urandom | 1), 3'd2, 1'b0);
    cmd(CMD_TO_RUN, 2'd0, pw, 3'd3, 1'b1);
    cmd(CMD_LOCK, 2'd0, pw, 3'd3, 1'b1);
    cmd(CMD_DOWNLOAD, 2'd0, pw, 3'd3, 1'b0);
    for (int t = 1; t < 4; t++) cmd(CMD_RESET, 2'(t), pw, 3'd3, 1'b0);
    wr(A_CTRL, 32'h1);
    cmd(CMD_TO_IDLE, 2'd0, pw, 3'd2, 1'b1);
    chk(std_in_hold, 1'b1);
    wr(A_IRQ_STS, 32'h1f);
    wr(A_IRQ_MASK, 32'h2);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    cmd(CMD_UNLOCK, 2'd0, ~pw, 3'd2, 1'b0);
    chk(irq, 1'b1);
    wr(A_IRQ_STS, 32'h2);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    rd(8'h20);
    chk(r, RESP_SLVERR);
    chk(d, 32'h0);
    wr(8'h24, 32'h1);
    chk(r, RESP_SLVERR);
    wr(A_CTRL, 32'h1);
    chk(r, RESP_OKAY);
    sw_setting <= ~sw_setting;
    st(3'd4);
    cmd(CMD_DOWNLOAD, 2'd0, pw, 3'd4, 1'b0);
    crit_err <= 1'b1;
    st(3'd5);
    cmd(CMD_MONITOR, 2'd0, pw, 3'd5, 1'b0);
    // mid-run reset: the stored password must still be enforced
    crit_err <= 1'b0;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    cmd(CMD_DOWNLOAD, 2'd0, ~pw, 3'd1, 1'b0);
    cmd(CMD_DOWNLOAD, 2'd0, pw, 3'd2, 1'b1);
    stop_test();
  end
endmodule : tb_safety_controller_mode_fsm
`default_nettype wire
